// ---- hw/pmic_i2c_target_port.v ----
// Serial target port: bus slave that writes control registers and reads status.
// Assumes scl and sda come from external pulled-up wires, sampled on mclk (100 MHz).
//
// Summary of operation
// (R1) Works for bus clock up to 400 kHz; controller must not exceed.
// (R2) General call address is neither acknowledged nor acted upon.
// (R3) A read sets busy_r until a stop; a start while busy is served like any other.
// (R4) Data line driven open-drain only; clock line is input only.
// (R5) Data bits are sampled on the rising edge of the bus clock.
// (R6) Read data driven bit by bit following the controller's clock.
// (R7) Default target address is 0x4A unless the address option is fitted and the select pin is high.
// (R8) With the option, the address-select pin level changes the address.
// (R9) Status registers 12 and 14 clear bits written with one.
// (R10) Subaddress byte selects the register used by the data bytes.
// (R11) Write: addr, sub, data. Read: addr, sub, restart, addr+R, data, nack.
// (R12) Manual-reset event flag clears when the controller writes one.
`timescale 1ns/1ps
`default_nettype none
`include "pmic_i2c_regs.vh"

module pmic_i2c_target_port #(
   parameter ADDR_OPTION = 0,
   parameter AW = `REG_AW
) (
   input wire mclk,
   input wire rst_b,
   input wire scl_in,
   input wire sda_in,
   output wire sda_out,
   output wire sda_oe_b,
   input wire address_select_pin,
   input wire [7:0] stat_a_set,
   input wire [7:0] stat_b_set,
   input wire manual_reset_event,
   output reg manual_reset_event_flag_r,
   output reg [7:0] ctrl_wr_data_r,
   output reg [AW-1:0] ctrl_wr_addr_r,
   output reg ctrl_wr_stb_r,
   output reg busy_r
);

   // ==========================================================
   // States
   localparam ST_IDLE = 3'd0;
   localparam ST_ADDR = 3'd1;
   localparam ST_ACK = 3'd2;
   localparam ST_SUB = 3'd3;
   localparam ST_WDATA = 3'd4;
   localparam ST_RDATA = 3'd5;
   localparam ST_RACK = 3'd6;

   // ==========================================================
   // Three-stage synchronisers
   reg [2:0] scl_sync_r;
   reg [2:0] sda_sync_r;
   reg scl_r;
   reg sda_r;

   // Capture pins; a level counts once stages two and three agree
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         scl_sync_r <= 3'h7;
         sda_sync_r <= 3'h7;
         scl_r <= 1'b1;
         sda_r <= 1'b1;
      end else begin
         scl_sync_r <= {scl_sync_r[1:0], scl_in}; // R1 R4
         sda_sync_r <= {sda_sync_r[1:0], sda_in};
         if (scl_sync_r[1] == scl_sync_r[2]) begin
            scl_r <= scl_sync_r[2];
         end
         if (sda_sync_r[1] == sda_sync_r[2]) begin
            sda_r <= sda_sync_r[2];
         end
      end
   end

   // ==========================================================
   // Bus events
   reg scl_d_r;
   reg sda_d_r;
   wire scl_rise = scl_r & ~scl_d_r; // R5
   wire scl_fall = ~scl_r & scl_d_r;
   wire start_ev = scl_r & scl_d_r & sda_d_r & ~sda_r;
   wire stop_ev = scl_r & scl_d_r & ~sda_d_r & sda_r;

   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end else begin
         scl_d_r <= scl_r;
         sda_d_r <= sda_r;
      end
   end

   // ==========================================================
   // Address selection, pin sampled continuously after reset release
   reg [2:0] addr_sync_r;
   reg addr_sel_r;
   wire [6:0] my_addr = (ADDR_OPTION != 0 && addr_sel_r) ?
      `TGT_ADDR_ALT : `TGT_ADDR_DEFAULT; // R7 R8

   // Pin passes three flops; level taken once stages two and three agree
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         addr_sync_r <= 3'h0;
         addr_sel_r <= 1'b0;
      end else begin
         addr_sync_r <= {addr_sync_r[1:0], address_select_pin};
         if (addr_sync_r[1] == addr_sync_r[2]) begin
            addr_sel_r <= addr_sync_r[2]; // R8
         end
      end
   end

   // Status register decode used by the write path only
   function is_status;
      input [AW-1:0] a;
      begin
         is_status = (a == `REG_STAT_A) || (a == `REG_STAT_B);
      end
   endfunction

   // ==========================================================
   // Transfer engine
   reg [2:0] state_r;
   reg [2:0] ret_r;
   reg [3:0] bit_cnt_r;
   reg [7:0] shift_r;
   reg [AW-1:0] sub_r;
   reg sda_drive_r;
   reg wr_pend_r;
   reg [7:0] stat_a_r;
   reg [7:0] stat_b_r;
   wire [7:0] mem_rd;
   reg mem_we_r;
   reg [7:0] mem_wd_r;

   // Read data source: status registers live in flops, others in the store
   wire [7:0] rd_byte = (sub_r == `REG_STAT_A) ? stat_a_r :
      (sub_r == `REG_STAT_B) ? stat_b_r : mem_rd;

   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         state_r <= ST_IDLE;
         ret_r <= ST_IDLE;
         bit_cnt_r <= 4'h0;
         shift_r <= 8'h00;
         sub_r <= {AW{1'b0}};
         sda_drive_r <= 1'b0;
         wr_pend_r <= 1'b0;
         busy_r <= 1'b0;
         mem_we_r <= 1'b0;
         mem_wd_r <= 8'h00;
      end else begin
         mem_we_r <= 1'b0;
         if (stop_ev) begin
            state_r <= ST_IDLE;
            sda_drive_r <= 1'b0;
            busy_r <= 1'b0; // R3
         end else if (start_ev && !busy_r) begin
            // A start outside a read opens an address phase; one during a read does the same
            state_r <= ST_ADDR;
            bit_cnt_r <= 4'h0;
            sda_drive_r <= 1'b0;
         end else if (start_ev && busy_r) begin
            state_r <= ST_ADDR; // R3
            bit_cnt_r <= 4'h0;
            sda_drive_r <= 1'b0;
         end else begin
            case (state_r)
               ST_ADDR, ST_SUB, ST_WDATA: begin
                  if (scl_rise) begin
                     shift_r <= {shift_r[6:0], sda_r}; // R5
                     bit_cnt_r <= bit_cnt_r + 4'h1;
                  end else if (scl_fall && bit_cnt_r == 4'h8) begin
                     bit_cnt_r <= 4'h0;
                     state_r <= ST_ACK;
                     if (state_r == ST_ADDR) begin
                        if (shift_r[7:1] == my_addr && shift_r[7:1] != `GEN_CALL_ADDR) begin
                           sda_drive_r <= 1'b1; // R2 R7
                           ret_r <= shift_r[0] ? ST_RDATA : ST_SUB; // R11
                           busy_r <= busy_r | shift_r[0]; // R3
                        end else begin
                           state_r <= ST_IDLE; // R2
                        end
                     end else if (state_r == ST_SUB) begin
                        sub_r <= shift_r[AW-1:0]; // R10
                        sda_drive_r <= 1'b1;
                        ret_r <= ST_WDATA;
                     end else begin
                        sda_drive_r <= 1'b1;
                        wr_pend_r <= 1'b1;
                        ret_r <= ST_WDATA;
                     end
                  end
               end
               ST_ACK: begin
                  if (wr_pend_r) begin
                     // Commit the written byte to the subaddressed register
                     wr_pend_r <= 1'b0;
                     if (!is_status(sub_r)) begin
                        mem_we_r <= 1'b1; // R10
                        mem_wd_r <= shift_r;
                     end
                  end
                  if (scl_fall) begin
                     sda_drive_r <= 1'b0;
                     if (ret_r == ST_RDATA) begin
                        shift_r <= rd_byte; // R6
                        sda_drive_r <= ~rd_byte[7];
                        bit_cnt_r <= 4'h1;
                     end
                     state_r <= ret_r;
                  end
               end
               ST_RDATA: begin
                  if (scl_fall) begin
                     if (bit_cnt_r == 4'h8) begin
                        sda_drive_r <= 1'b0;
                        state_r <= ST_RACK;
                     end else begin
                        sda_drive_r <= ~shift_r[7 - bit_cnt_r[2:0]]; // R6 R4
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                     end
                  end
               end
               ST_RACK: begin
                  // Controller ack continues the read, nack ends it
                  if (scl_rise) begin
                     if (sda_r) begin
                        state_r <= ST_IDLE; // R11
                     end else begin
                        sub_r <= sub_r + {{(AW-1){1'b0}}, 1'b1};
                        ret_r <= ST_RDATA;
                        state_r <= ST_ACK;
                     end
                  end
               end
               default: begin
                  state_r <= ST_IDLE;
               end
            endcase
         end
      end
   end

   // ==========================================================
   // Status registers: hardware sets win over write-one clears
   wire stat_wr = ST_ACK == state_r && wr_pend_r;

   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         stat_a_r <= `REG_RESET_VAL;
         stat_b_r <= `REG_RESET_VAL;
      end else begin
         stat_a_r <= (stat_a_r & ~((stat_wr && sub_r == `REG_STAT_A) ? shift_r : 8'h00))
            | stat_a_set; // R9
         stat_b_r <= (stat_b_r & ~((stat_wr && sub_r == `REG_STAT_B) ? shift_r : 8'h00))
            | stat_b_set | ({7'h00, manual_reset_event} << `MR_EVENT_BIT); // R9 R12
      end
   end

   // Manual reset event flag mirrors its status bit
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         manual_reset_event_flag_r <= 1'b0;
      end else begin
         manual_reset_event_flag_r <= stat_b_r[`MR_EVENT_BIT]; // R12
      end
   end

   // Control write strobe to the regulator logic
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_wr_stb_r <= 1'b0;
         ctrl_wr_data_r <= 8'h00;
         ctrl_wr_addr_r <= {AW{1'b0}};
      end else begin
         ctrl_wr_stb_r <= mem_we_r;
         if (mem_we_r) begin
            ctrl_wr_data_r <= mem_wd_r;
            ctrl_wr_addr_r <= sub_r;
         end
      end
   end

   // ==========================================================
   // Register memory
   reg_store #(.AW(AW), .DEPTH(`REG_DEPTH)) u_store (
      .mclk(mclk),
      .rst_b(rst_b),
      .wr_en(mem_we_r),
      .wr_addr(sub_r),
      .wr_data(mem_wd_r),
      .rd_addr(sub_r),
      .rd_data_r(mem_rd)
   );

   // Open-drain data: only ever pulls low; enable low while driving
   assign sda_out = 1'b0; // R4
   assign sda_oe_b = ~sda_drive_r; // R4

endmodule
`default_nettype wire

// ---- inc/pmic_i2c_regs.vh ----
// Constants for the serial target port: bus address, register map and timing.
// Assumes a 100 MHz system clock; included by bare name from hw/ files.
`ifndef PMIC_I2C_REGS_VH
`define PMIC_I2C_REGS_VH

// ==========================================================
// Target address
`define TGT_ADDR_DEFAULT 7'h4A
`define TGT_ADDR_ALT 7'h4B
`define GEN_CALL_ADDR 7'h00

// ==========================================================
// Register map
`define REG_AW 4
`define REG_DEPTH 16
`define REG_STAT_A 4'hC
`define REG_STAT_B 4'hE
`define MR_EVENT_BIT 0
`define REG_RESET_VAL 8'h00

// ==========================================================
// Timing
`define SCL_MAX_KHZ 400
`define MCLK_MHZ 100

`endif

// ---- hw/reg_store.v ----
// Small register memory for the target port, one write port, one read port.
// Assumes single clock; read data come out of a register one cycle after the address.
`timescale 1ns/1ps
`default_nettype none
`include "pmic_i2c_regs.vh"

module reg_store #(
   parameter AW = `REG_AW,
   parameter DEPTH = `REG_DEPTH
) (
   input wire mclk,
   input wire rst_b,
   input wire wr_en,
   input wire [AW-1:0] wr_addr,
   input wire [7:0] wr_data,
   input wire [AW-1:0] rd_addr,
   output reg [7:0] rd_data_r
);

   // ==========================================================
   // Storage
   reg [7:0] mem_r [0:DEPTH-1];
   integer i;

   // Write port and registered read
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         for (i = 0; i < DEPTH; i = i + 1) begin
            mem_r[i] <= `REG_RESET_VAL;
         end
         rd_data_r <= `REG_RESET_VAL;
      end else begin
         if (wr_en) begin
            mem_r[wr_addr] <= wr_data;
         end
         rd_data_r <= mem_r[rd_addr];
      end
   end

endmodule
`default_nettype wire

// ---- dv/port_monitor.sv ----
// Checker for the serial target port, bound to its top module.
// Assumes one mclk domain with asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module port_monitor (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe_b,
   input wire logic manual_reset_event,
   input wire logic manual_reset_event_flag_r,
   input wire logic ctrl_wr_stb_r,
   input wire logic busy_r
);
   // ==========================================
   // Helper logic
   logic [8:0] low_cnt_r;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   // Cycles the data line has been pulled low in a row
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b)
         low_cnt_r <= 9'h000;
      else if (sda_oe_b)
         low_cnt_r <= 9'h000;
      else
         low_cnt_r <= low_cnt_r + 9'h001;
   end
   // ==========================================
   // Assertions
   sda_drive_a: assert property (scl_in && $changed(sda_in) |->
      sda_oe_b && $past(sda_oe_b) && sda_out == 1'b0)
      else $error("data line moved by device while clock high");
   oe_edge_a: assert property ($changed(sda_oe_b) |-> !scl_in)
      else $error("data drive changed while clock high");
   stb_pulse_a: assert property (ctrl_wr_stb_r |=> !ctrl_wr_stb_r)
      else $error("write strobe longer than one cycle");
   stb_ack_a: assert property (ctrl_wr_stb_r |-> !sda_oe_b && !scl_in)
      else $error("write strobe outside acknowledge");
   mr_set_a: assert property (manual_reset_event |-> ##[1:3] manual_reset_event_flag_r)
      else $error("event flag not set");
   mr_cause_a: assert property ($rose(manual_reset_event_flag_r) |->
      $past(manual_reset_event) || $past(manual_reset_event, 2))
      else $error("event flag set without event");
   busy_stop_a: assert property ($fell(busy_r) |-> scl_in && sda_in)
      else $error("read hold released outside stop");
   oe_hold_a: assert property (low_cnt_r < 9'd200)
      else $error("data line held low too long");
endmodule
bind pmic_i2c_target_port port_monitor u_mon (.mclk(mclk), .rst_b(rst_b), .scl_in(scl_in),
   .sda_in(sda_in), .sda_out(sda_out), .sda_oe_b(sda_oe_b),
   .manual_reset_event(manual_reset_event),
   .manual_reset_event_flag_r(manual_reset_event_flag_r),
   .ctrl_wr_stb_r(ctrl_wr_stb_r), .busy_r(busy_r));
`default_nettype wire

// ---- dv/i2c_ctrl_model.sv ----
// Bus controller model: makes the serial clock and pulls the data line.
// Assumes the bench joins sda_low with the device's drive and a pull-up.
`timescale 1ns/1ps
`default_nettype none
module i2c_ctrl_model (
   output logic scl,
   output logic sda_low,
   input wire logic sda
);
   localparam time Q = 40ns;
   // Clock rests high and data released between frames
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   // Start, or repeated start when the clock is low
   task automatic start();
      if (!scl) begin
         #Q sda_low = 1'b0;
         #Q scl = 1'b1;
      end
      #Q sda_low = 1'b1;
      #Q scl = 1'b0;
   endtask
   // Nine bits MSB first; data moves only while the clock is low
   task automatic byte9(input logic [8:0] tx, output logic [8:0] rx);
      for (int i = 8; i >= 0; i--) begin
         #Q sda_low = !tx[i];
         #Q scl = 1'b1;
         #Q rx[i] = sda;
         #Q scl = 1'b0;
      end
   endtask
   // Stop, then idle
   task automatic stop();
      #Q sda_low = 1'b1;
      #Q scl = 1'b1;
      #Q sda_low = 1'b0;
      #(4*Q);
   endtask
endmodule
`default_nettype wire

// ---- dv/pmic_i2c_target_port_tb.sv ----
// Self-checking bench for the serial target port.
// Assumes the controller model and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "pmic_i2c_regs.vh"
module pmic_i2c_target_port_tb;
   localparam logic [6:0] ADR = `TGT_ADDR_DEFAULT;
   localparam logic [7:0] SA = {4'h0, `REG_STAT_A};
   localparam logic [7:0] SB = {4'h0, `REG_STAT_B};
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic sel = 1'b0;
   logic [7:0] set_a = 8'h00;
   logic [7:0] set_b = 8'h00;
   logic mr_ev = 1'b0;
   wire scl, sda_low, sda_w, sda_out, sda_oe_b, mr_flag, stb, busy;
   wire [7:0] wd;
   wire [3:0] wa;
   int fail_count = 0;
   int checks_done = 0;
   int cycles = 0;
   int stb_n = 0;
   always #5 mclk = ~mclk;
   // Open-drain wire with pull-up
   assign sda_w = (!sda_oe_b ? sda_out : 1'b1) & !sda_low;
   i2c_ctrl_model ctl (.scl(scl), .sda_low(sda_low), .sda(sda_w));
   pmic_i2c_target_port #(.ADDR_OPTION(1)) DUT (.mclk(mclk), .rst_b(rst_b), .scl_in(scl),
      .sda_in(sda_w), .sda_out(sda_out), .sda_oe_b(sda_oe_b), .address_select_pin(sel),
      .stat_a_set(set_a), .stat_b_set(set_b), .manual_reset_event(mr_ev),
      .manual_reset_event_flag_r(mr_flag), .ctrl_wr_data_r(wd), .ctrl_wr_addr_r(wa),
      .ctrl_wr_stb_r(stb), .busy_r(busy));
   // ==========================================
   // Shared tasks
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d, mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic tick();
      @(posedge mclk);
      #1;
   endtask
   task automatic send(input logic [7:0] b, output logic k);
      logic [8:0] r;
      ctl.byte9({b, 1'b1}, r);
      k = !r[0];
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] sub, input logic [7:0] d,
      input logic ok);
      logic k;
      tick();
      ctl.start();
      send({a, 1'b0}, k);
      check(k, ok);
      send(sub, k);
      check(k, ok);
      send(d, k);
      check(k, ok);
      ctl.stop();
   endtask
   task automatic rd(input logic [7:0] sub, input logic [7:0] exp);
      logic k;
      logic [8:0] r;
      tick();
      ctl.start();
      send({ADR, 1'b0}, k);
      check(k, 1'b1);
      send(sub, k);
      check(k, 1'b1);
      ctl.start();
      send({ADR, 1'b1}, k);
      check(k, 1'b1);
      ctl.byte9(9'h1FF, r);
      check(r[8:1], exp);
      check(busy, 1'b1);
      ctl.stop();
      repeat (8) tick();
      check(busy, 1'b0);
   endtask
   // ==========================================
   // Scenarios
   task automatic t_write();
      int n;
      n = stb_n;
      wr(ADR, 8'h03, 8'hA5, 1'b1);
      check(8'(stb_n - n), 8'h01);
      check(wa, 4'h3);
      wr(ADR, 8'h05, 8'h3C, 1'b1);
      check(wd, 8'h3C);
      rd(8'h03, 8'hA5);
      $display("t_write done");
   endtask
   task automatic t_address();
      wr(`GEN_CALL_ADDR, 8'h03, 8'h5A, 1'b0);
      check(wd, 8'h3C);
      wr(`TGT_ADDR_ALT, 8'h03, 8'h5A, 1'b0);
      sel = 1'b1;
      wr(ADR, 8'h03, 8'h5A, 1'b0);
      wr(`TGT_ADDR_ALT, 8'h06, 8'h77, 1'b1);
      check(wd, 8'h77);
      sel = 1'b0;
      $display("t_address done");
   endtask
   task automatic t_status();
      tick();
      set_a = 8'h81;
      set_b = 8'h02;
      mr_ev = 1'b1;
      tick();
      set_a = 8'h00;
      set_b = 8'h00;
      mr_ev = 1'b0;
      repeat (4) tick();
      check(mr_flag, 1'b1);
      rd(SA, 8'h81);
      wr(ADR, SA, 8'h01, 1'b1);
      rd(SA, 8'h80);
      wr(ADR, SA, 8'h00, 1'b1);
      rd(SA, 8'h80);
      rd(SB, 8'h03);
      wr(ADR, SB, 8'h01, 1'b1);
      check(mr_flag, 1'b0);
      rd(SB, 8'h02);
      $display("t_status done");
   endtask
   // ==========================================
   // Main sequence and hang limit
   initial begin
      repeat (10) @(posedge mclk);
      #1 rst_b = 1'b1;
      repeat (10) tick();
      t_write();
      t_address();
      t_status();
      wrap_up();
   end
   always @(posedge mclk) begin
      cycles++;
      if (stb === 1'b1)
         stb_n++;
      if (cycles == 40000) begin
         fail_count++;
         wrap_up();
      end
   end
endmodule
`default_nettype wire
